// ---- common/clc_pkg.sv ----
// Constants, field layouts and carrier types of the configurable logic cell.
// Assumes a 32-bit APB slave with byte offsets on an 8-bit address.
package clc_pkg;

    // Sizes of the cell.
    localparam int unsigned NUM_IN = 32;
    localparam int unsigned SEL_W = 5;
    localparam int unsigned NUM_GATES = 4;
    localparam int unsigned NUM_PINS = 4;
    localparam int unsigned NUM_CELLS = 3;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // Input selection codes.
    localparam logic [4:0] SEL_PIN_FIRST = 5'h00;
    localparam logic [4:0] SEL_FB_FIRST = 5'h04;
    localparam logic [4:0] SEL_RSV_A = 5'h07;
    localparam logic [4:0] SEL_RSV_B = 5'h11;
    localparam logic [4:0] SEL_ZERO_CROSS = 5'h13;
    localparam logic [4:0] SEL_PIN_CHANGE = 5'h1b;
    localparam logic [4:0] SEL_CONV_RC = 5'h1c;
    localparam logic [4:0] SEL_SLOW_OSC = 5'h1d;
    localparam logic [4:0] SEL_FAST_OSC = 5'h1e;
    localparam logic [4:0] SEL_SYS_CLK = 5'h1f;

    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_POL = 8'h04;
    localparam logic [7:0] OFF_SEL = 8'h08;
    localparam logic [7:0] OFF_GATE = 8'h0c;
    localparam logic [7:0] OFF_FLAG = 8'h10;
    localparam logic [7:0] OFF_MIRROR = 8'h14;

    // Field positions.
    localparam int unsigned CTRL_EN_BIT = 7;
    localparam int unsigned CTRL_OUT_BIT = 5;
    localparam int unsigned CTRL_RISE_BIT = 4;
    localparam int unsigned CTRL_FALL_BIT = 3;
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned MODE_W = 3;
    localparam int unsigned POL_OUT_BIT = 7;
    localparam int unsigned POL_GATE_LSB = 0;
    localparam int unsigned FIELD_STRIDE = 8;
    localparam int unsigned FLAG_BIT = 0;

    // Logic function codes.
    localparam logic [2:0] MODE_AND_OR = 3'h0;
    localparam logic [2:0] MODE_OR_XOR = 3'h1;
    localparam logic [2:0] MODE_AND4 = 3'h2;
    localparam logic [2:0] MODE_SR = 3'h3;
    localparam logic [2:0] MODE_DFF = 3'h4;
    localparam logic [2:0] MODE_DFF2 = 3'h5;
    localparam logic [2:0] MODE_JK = 3'h6;
    localparam logic [2:0] MODE_LATCH = 3'h7;

    typedef struct packed {
        logic [3:0] pin_input;
        logic fast_internal_osc;
        logic slow_internal_osc;
        logic converter_rc_clock;
    } clc_async_s;

    typedef struct packed {
        logic output_invert;
        logic [3:0] gate_invert;
        logic [3:0][4:0] input_select_field;
        logic [3:0][7:0] gate_enable;
    } clc_cfg_s;

    typedef struct packed {
        logic cell_enable_bit;
        logic rise_irq_enable;
        logic fall_irq_enable;
        logic [2:0] logic_function_select;
    } clc_ctrl_s;

    typedef struct packed {
        clc_ctrl_s ctrl;
        logic flag;
        logic out;
        logic out_prev;
        logic seq;
        logic g1_prev;
        logic sysclk_div;
        logic [31:0] prdata;
        logic pslverr;
    } clc_state_s;

    typedef struct packed {
        clc_async_s s1;
        clc_async_s s2;
    } clc_sync_s;

    localparam clc_state_s STATE_RST = '0;
    localparam clc_sync_s SYNC_RST = '0;

endpackage

// ---- verilog/clc_sync.sv ----
// Two-flop synchroniser for the pins and oscillators that feed the cell.
// Assumes the inputs are asynchronous to pclk.
`timescale 1ns/100ps
`default_nettype none
module clc_sync (
    // Clock, reset and freeze.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Raw and synchronised signals.
    input wire clc_pkg::clc_async_s async_in,
    output var clc_pkg::clc_async_s sync_out
);
    clc_pkg::clc_sync_s q, d;

    // The first stage feeds only the second stage.
    always_comb begin
        d = q;
        d.s1 = async_in;
        d.s2 = q.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= clc_pkg::SYNC_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    assign sync_out = q.s2;
endmodule // clc_sync
`default_nettype wire

// ---- verilog/clc_cfg_store.sv ----
// Storage of the selection, gating and polarity settings.
// Assumes write strobes come from the bus slave at the access edge.
`timescale 1ns/100ps
`default_nettype none
module clc_cfg_store (
    // Clock and freeze.
    input wire logic pclk,
    input wire logic ce,
    // Write port.
    input wire logic pol_we,
    input wire logic sel_we,
    input wire logic gate_we,
    input wire logic [31:0] wdata,
    // Stored settings.
    output var clc_pkg::clc_cfg_s cfg
);
    clc_pkg::clc_cfg_s d, q;

    always_comb begin
        d = q;
        if (pol_we) begin
            d.output_invert = wdata[clc_pkg::POL_OUT_BIT];
            d.gate_invert = wdata[clc_pkg::POL_GATE_LSB +: clc_pkg::NUM_GATES];
        end
        for (int k = 0; k < clc_pkg::NUM_GATES; k++) begin
            if (sel_we) begin
                d.input_select_field[k] = wdata[k * clc_pkg::FIELD_STRIDE +: clc_pkg::SEL_W]; // [R08]
            end
            if (gate_we) begin
                d.gate_enable[k] = wdata[k * clc_pkg::FIELD_STRIDE +: clc_pkg::FIELD_STRIDE];
            end
        end
    end

    // No reset: settings are unknown at power-up and survive every reset.
    always_ff @(posedge pclk) begin // [R07] [R20]
        if (ce) begin
            q <= d;
        end
    end

    assign cfg = q;
endmodule // clc_cfg_store
`default_nettype wire

// ---- verilog/clc_cell.sv ----
// One configurable logic cell with its APB register slave.
// Assumes same-clock peripheral and peer-cell signals, asynchronous pins and oscillators.
//
// Behaviour
// [R01] Select, gate, combine, then invert the output.
// [R02] Four muxes pick from 32 signals each.
// [R03] Top codes pick clock and oscillator sources.
// [R04] Codes 0 to 3 pick pin inputs.
// [R05] Codes 4 to 6 feed back cell outputs.
// [R06] Codes pick zero-cross and pin-change signals.
// [R07] Select fields start undefined after power-up.
// [R08] All settings writable while running.
// [R09] Software disables before reconfiguring, enables last.
// [R10] Gate passes only its enabled inputs.
// [R11] Per-gate bit inverts gate result.
// [R12] Three-bit field chooses the logic function.
// [R13] One bit inverts the final output.
// [R14] Rising and falling detectors watch the output.
// [R15] Enabled edge sets the interrupt flag.
// [R16] Rise and fall enables live in control.
// [R17] Software clears flag; simultaneous edge wins.
// [R18] Mirror register holds all cell outputs.
// [R19] Reset clears the control register.
// [R20] Reset keeps select, gate and polarity.
// [R21] Cell keeps running while its sources run.
// [R22] Edges compare output with previous cycle.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module clc_cell #(
    parameter int unsigned CELL_INDEX = 0
) (
    // Clock, reset and freeze.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Signal sources.
    input wire clc_pkg::clc_async_s async_in,
    input wire logic [31:0] periph_in,
    input wire logic zero_cross_output,
    input wire logic pin_change_flag,
    input wire logic [2:0] peer_out,
    // Cell results.
    output logic cell_output_bit,
    output logic cell_irq_flag
);
    clc_pkg::clc_state_s q, d;
    clc_pkg::clc_cfg_s cfg;
    clc_pkg::clc_async_s src;
    logic [31:0] in_vec;
    logic [2:0] fb;
    logic [3:0] data_sel;
    logic [3:0] g;
    logic comb_val;
    logic seq_d;
    logic g1_rise;
    logic func_val;
    logic rise;
    logic fall;
    logic flag_set;
    logic flag_clr;
    logic setup;
    logic access;
    logic wr;
    logic ctrl_wr;
    logic [31:0] rdata;

    // Picks one signal of the 32 by its select code.
    function automatic logic pick(input logic [31:0] v, input logic [4:0] s);
        pick = v[s];
    endfunction

    // Ors together the true and negated data enabled into one gate.
    function automatic logic gate_or(input logic [7:0] en, input logic [3:0] dv);
        logic r;
        r = 1'b0;
        for (int j = 0; j < clc_pkg::NUM_GATES; j++) begin
            r = r | (en[2 * j + 1] & dv[j]) | (en[2 * j] & ~dv[j]);
        end
        gate_or = r;
    endfunction

    // Tells whether an address holds a register.
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == clc_pkg::OFF_CTRL) || (a == clc_pkg::OFF_POL) ||
                  (a == clc_pkg::OFF_SEL) || (a == clc_pkg::OFF_GATE) ||
                  (a == clc_pkg::OFF_FLAG) || (a == clc_pkg::OFF_MIRROR);
    endfunction

    clc_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in(async_in),
        .sync_out(src)
    );

    clc_cfg_store u_cfg (
        .pclk(pclk),
        .ce(ce),
        .pol_we(wr && (paddr == clc_pkg::OFF_POL)),
        .sel_we(wr && (paddr == clc_pkg::OFF_SEL)),
        .gate_we(wr && (paddr == clc_pkg::OFF_GATE)),
        .wdata(pwdata),
        .cfg(cfg)
    );

    // Bus phases; no transfer completes while frozen.
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign pready = access & ce;
    assign wr = access & pwrite & ce & addr_ok(paddr); // [R08]
    assign ctrl_wr = wr & (paddr == clc_pkg::OFF_CTRL);

    // Feedback and mirror copy: peer outputs with this cell's own registered output.
    always_comb begin
        fb = peer_out;
        fb[CELL_INDEX] = q.out; // [R18]
    end

    // Candidate inputs of the four multiplexers.
    always_comb begin
        in_vec = periph_in;
        in_vec[clc_pkg::SEL_PIN_FIRST +: clc_pkg::NUM_PINS] = src.pin_input; // [R04]
        in_vec[clc_pkg::SEL_FB_FIRST +: clc_pkg::NUM_CELLS] = fb; // [R05]
        in_vec[clc_pkg::SEL_RSV_A] = 1'b0;
        in_vec[clc_pkg::SEL_RSV_B] = 1'b0;
        in_vec[clc_pkg::SEL_ZERO_CROSS] = zero_cross_output; // [R06]
        in_vec[clc_pkg::SEL_PIN_CHANGE] = pin_change_flag; // [R06]
        in_vec[clc_pkg::SEL_CONV_RC] = src.converter_rc_clock; // [R03]
        in_vec[clc_pkg::SEL_SLOW_OSC] = src.slow_internal_osc; // [R03]
        in_vec[clc_pkg::SEL_FAST_OSC] = src.fast_internal_osc; // [R03]
        in_vec[clc_pkg::SEL_SYS_CLK] = q.sysclk_div; // [R03]
    end

    // Data selection then gating with per-gate inversion.
    for (genvar k = 0; k < clc_pkg::NUM_GATES; k++) begin : g_gate
        assign data_sel[k] = pick(in_vec, cfg.input_select_field[k]); // [R02]
        assign g[k] = gate_or(cfg.gate_enable[k], data_sel) ^ cfg.gate_invert[k]; // [R10] [R11]
    end

    // Logic function; combinational modes follow their inputs without any stored state.
    always_comb begin
        comb_val = 1'b0;
        seq_d = q.seq;
        g1_rise = g[0] & ~q.g1_prev;
        case (q.ctrl.logic_function_select) // [R12] [R21]
            clc_pkg::MODE_AND_OR: begin
                comb_val = (g[0] & g[1]) | (g[2] & g[3]);
            end
            clc_pkg::MODE_OR_XOR: begin
                comb_val = (g[0] | g[1]) ^ (g[2] | g[3]);
            end
            clc_pkg::MODE_AND4: begin
                comb_val = &g;
            end
            clc_pkg::MODE_SR: begin
                if (g[0] | g[1]) begin
                    seq_d = 1'b1;
                end else if (g[2] | g[3]) begin
                    seq_d = 1'b0;
                end
                comb_val = seq_d;
            end
            clc_pkg::MODE_DFF: begin
                if (g[2]) begin
                    seq_d = 1'b0;
                end else if (g[3]) begin
                    seq_d = 1'b1;
                end else if (g1_rise) begin
                    seq_d = g[1];
                end
                comb_val = seq_d;
            end
            clc_pkg::MODE_DFF2: begin
                if (g[2]) begin
                    seq_d = 1'b0;
                end else if (g1_rise) begin
                    seq_d = g[1] & g[3];
                end
                comb_val = seq_d;
            end
            clc_pkg::MODE_JK: begin
                if (g[2]) begin
                    seq_d = 1'b0;
                end else if (g1_rise) begin
                    seq_d = (g[1] & ~q.seq) | (~g[3] & q.seq);
                end
                comb_val = seq_d;
            end
            default: begin
                if (g[0]) begin
                    seq_d = 1'b0;
                end else if (g[3]) begin
                    seq_d = 1'b1;
                end else if (g[2]) begin
                    seq_d = g[1];
                end
                comb_val = seq_d;
            end
        endcase
        func_val = comb_val ^ cfg.output_invert; // [R13]
    end

    // Edge detectors compare the output with its previous registered value.
    assign rise = q.out & ~q.out_prev; // [R14] [R22]
    assign fall = ~q.out & q.out_prev; // [R14] [R22]
    assign flag_set = (rise & q.ctrl.rise_irq_enable) | (fall & q.ctrl.fall_irq_enable); // [R15] [R16]
    assign flag_clr = wr & (paddr == clc_pkg::OFF_FLAG) & pwdata[clc_pkg::FLAG_BIT];

    // Register read data.
    always_comb begin
        rdata = '0;
        case (paddr)
            clc_pkg::OFF_CTRL: begin
                rdata[clc_pkg::CTRL_EN_BIT] = q.ctrl.cell_enable_bit;
                rdata[clc_pkg::CTRL_OUT_BIT] = q.out;
                rdata[clc_pkg::CTRL_RISE_BIT] = q.ctrl.rise_irq_enable;
                rdata[clc_pkg::CTRL_FALL_BIT] = q.ctrl.fall_irq_enable;
                rdata[clc_pkg::CTRL_MODE_LSB +: clc_pkg::MODE_W] = q.ctrl.logic_function_select;
            end
            clc_pkg::OFF_POL: begin
                rdata[clc_pkg::POL_OUT_BIT] = cfg.output_invert;
                rdata[clc_pkg::POL_GATE_LSB +: clc_pkg::NUM_GATES] = cfg.gate_invert;
            end
            clc_pkg::OFF_SEL: begin
                for (int k = 0; k < clc_pkg::NUM_GATES; k++) begin
                    rdata[k * clc_pkg::FIELD_STRIDE +: clc_pkg::SEL_W] = cfg.input_select_field[k];
                end
            end
            clc_pkg::OFF_GATE: begin
                rdata = cfg.gate_enable;
            end
            clc_pkg::OFF_FLAG: begin
                rdata[clc_pkg::FLAG_BIT] = q.flag;
            end
            clc_pkg::OFF_MIRROR: begin
                rdata[clc_pkg::NUM_CELLS - 1:0] = fb; // [R18]
            end
            default: begin
                rdata = '0;
            end
        endcase
    end

    // Next state of the cell.
    always_comb begin
        d = q;
        d.sysclk_div = ~q.sysclk_div;
        if (ctrl_wr) begin
            d.ctrl.cell_enable_bit = pwdata[clc_pkg::CTRL_EN_BIT]; // [R08]
            d.ctrl.rise_irq_enable = pwdata[clc_pkg::CTRL_RISE_BIT]; // [R16]
            d.ctrl.fall_irq_enable = pwdata[clc_pkg::CTRL_FALL_BIT]; // [R16]
            d.ctrl.logic_function_select = pwdata[clc_pkg::CTRL_MODE_LSB +: clc_pkg::MODE_W];
        end
        d.out = q.ctrl.cell_enable_bit & func_val; // [R01]
        d.seq = q.ctrl.cell_enable_bit & seq_d;
        d.g1_prev = g[0];
        d.out_prev = q.out; // [R22]
        d.flag = flag_set | (q.flag & ~flag_clr); // [R17]
        if (setup) begin
            d.prdata = rdata;
            d.pslverr = ~addr_ok(paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= clc_pkg::STATE_RST; // [R19]
        end else if (ce) begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pslverr = q.pslverr & access;
    assign cell_output_bit = q.out;
    assign cell_irq_flag = q.flag;

    flag_rise_a: assert property ( // [R15]
        @(posedge pclk) disable iff (!presetn)
        ce && rise && q.ctrl.rise_irq_enable |=> q.flag)
        else $error("Enabled rising edge did not set the flag.");

    flag_fall_a: assert property ( // [R16]
        @(posedge pclk) disable iff (!presetn)
        ce && !q.out && $past(q.out) && q.ctrl.fall_irq_enable && !flag_clr |=> q.flag)
        else $error("Enabled falling edge did not set the flag.");

    set_wins_a: assert property ( // [R17]
        @(posedge pclk) disable iff (!presetn)
        ce && flag_set && flag_clr |=> q.flag)
        else $error("Clear won over a simultaneous edge.");

    flag_clear_a: assert property ( // [R17]
        @(posedge pclk) disable iff (!presetn)
        ce && q.flag && flag_clr && !flag_set |=> !q.flag)
        else $error("Flag not cleared by software.");

    out_disabled_a: assert property ( // [R01]
        @(posedge pclk) disable iff (!presetn)
        ce && !q.ctrl.cell_enable_bit |=> !cell_output_bit)
        else $error("Disabled cell drives its output.");

    xor_invert_a: assert property ( // [R13]
        @(posedge pclk) disable iff (!presetn)
        ce && q.ctrl.cell_enable_bit && q.ctrl.logic_function_select == clc_pkg::MODE_OR_XOR
        |=> q.out == $past(((g[0] | g[1]) ^ (g[2] | g[3])) ^ cfg.output_invert))
        else $error("Output does not follow function and polarity.");

    gate_empty_a: assert property ( // [R11]
        @(posedge pclk) disable iff (!presetn)
        ce && q.ctrl.cell_enable_bit && q.ctrl.logic_function_select == clc_pkg::MODE_AND4 &&
        cfg.gate_enable == '0 |=> q.out == $past((&cfg.gate_invert) ^ cfg.output_invert))
        else $error("Empty gates do not follow their polarity.");

    edge_seen_a: assert property ( // [R22]
        @(posedge pclk) disable iff (!presetn)
        ce && !q.out ##1 ce && q.out |-> rise)
        else $error("Rising output edge not detected.");

    edge_pulse_a: assert property ( // [R14]
        @(posedge pclk) disable iff (!presetn)
        ce && (rise || fall) |=> !(rise || fall) || (q.out != $past(q.out)))
        else $error("Edge pulse longer than one cycle.");

    mirror_read_a: assert property ( // [R18]
        @(posedge pclk) disable iff (!presetn)
        ce && setup && paddr == clc_pkg::OFF_MIRROR |=> prdata[CELL_INDEX] == $past(q.out))
        else $error("Mirror read misses the cell output.");

    reset_ctrl_a: assert property ( // [R19]
        @(posedge pclk)
        $rose(presetn) |-> q.ctrl == '0 && !q.flag)
        else $error("Control not cleared by reset.");
endmodule // clc_cell
`default_nettype wire

// ---- dv/clc_src_model.sv ----
// Source model for the cell: peripheral, peer-cell, pin and oscillator signals.
// Assumes the bench sets the wanted levels on cmd just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module clc_src_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Wanted levels, bit n for select code n.
    input wire logic [31:0] cmd,
    // Signals into the cell.
    output logic [31:0] periph_in,
    output logic zero_cross_output,
    output logic pin_change_flag,
    output logic [2:0] peer_out,
    output var clc_pkg::clc_async_s async_in
);
    logic [31:0] src_q;
    logic [2:0] osc_q;

    // Same-clock sources follow the command one edge later.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_q <= 32'h0;
            osc_q <= 3'h0;
        end else begin
            src_q <= cmd;
            osc_q <= osc_q + 3'h1;
        end
    end

    assign periph_in = src_q;
    assign zero_cross_output = src_q[19];
    assign pin_change_flag = src_q[27];
    assign peer_out = src_q[6:4];
    // Pins follow the command at once; the oscillators run except while reset holds them at zero.
    assign async_in = {cmd[3:0], osc_q};
endmodule // clc_src_model
`default_nettype wire

// ---- dv/tb_configurable_logic_cell.sv ----
// Testbench of the configurable logic cell: APB tasks and directed checks.
// Assumes the source model drives every signal input of the cell.
`timescale 1ns/100ps
`default_nettype none
module tb_configurable_logic_cell;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, zc, pcf, out, irq, err, prev_out;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, drive, periph_in, rd;
    logic [2:0] peer;
    clc_pkg::clc_async_s ain;
    int n_fail, checks, cyc;
    logic [4:0] codes [7] = '{5'h00, 5'h03, 5'h05, 5'h06, 5'h08, 5'h13, 5'h1b};
    logic [31:0] pols [3] = '{32'h2, 32'h4, 32'he};

    clc_cell #(.CELL_INDEX(0)) dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .async_in(ain),
        .periph_in(periph_in), .zero_cross_output(zc), .pin_change_flag(pcf),
        .peer_out(peer), .cell_output_bit(out), .cell_irq_flag(irq));

    clc_src_model src (.pclk(pclk), .presetn(presetn), .cmd(drive), .periph_in(periph_in),
        .zero_cross_output(zc), .pin_change_flag(pcf), .peer_out(peer), .async_in(ain));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic finish_test;
        if (n_fail == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer, entered just after a rising edge.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic settle;
        repeat (5) @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            finish_test();
        end
    end

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        drive = 32'h0;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(clc_pkg::OFF_CTRL, 1'b0, 32'h0);
        chk("ctrl after reset", rd, 32'h0);
        xfer(8'h18, 1'b0, 32'h0);
        chk("unmapped error", 32'(err), 32'h1);
        // Gate 1 passes data 1 true; gate 2 inverted so the output follows gate 1.
        xfer(clc_pkg::OFF_GATE, 1'b1, 32'h2);
        xfer(clc_pkg::OFF_POL, 1'b1, 32'h2);
        xfer(clc_pkg::OFF_SEL, 1'b1, 32'h0);
        xfer(clc_pkg::OFF_CTRL, 1'b1, 32'h80);
        foreach (codes[i]) begin
            xfer(clc_pkg::OFF_SEL, 1'b1, {27'h0, codes[i]});
            drive <= 32'h1 << codes[i];
            settle();
            chk("selected source high", 32'(out), 32'h1);
            drive <= 32'h0;
            settle();
            chk("selected source low", 32'(out), 32'h0);
        end
        xfer(clc_pkg::OFF_POL, 1'b1, 32'h82);
        settle();
        chk("output inverted", 32'(out), 32'h1);
        for (int m = 0; m < 3; m++) begin
            xfer(clc_pkg::OFF_POL, 1'b1, pols[m]);
            xfer(clc_pkg::OFF_CTRL, 1'b1, 32'h80 | m);
            drive <= 32'h0;
            settle();
            chk("function gate1 low", 32'(out), 32'(m == 1));
            drive <= 32'h1 << 27;
            settle();
            chk("function gate1 high", 32'(out), 32'(m != 1));
        end
        // Rise interrupt only.
        xfer(clc_pkg::OFF_POL, 1'b1, 32'h2);
        xfer(clc_pkg::OFF_CTRL, 1'b1, 32'h90);
        drive <= 32'h0;
        settle();
        xfer(clc_pkg::OFF_FLAG, 1'b1, 32'h1);
        chk("flag cleared", 32'(irq), 32'h0);
        drive <= 32'h1 << 27;
        settle();
        chk("rise sets flag", 32'(irq), 32'h1);
        xfer(clc_pkg::OFF_CTRL, 1'b0, 32'h0);
        chk("ctrl with output", rd, 32'hb0);
        xfer(clc_pkg::OFF_FLAG, 1'b0, 32'h0);
        chk("flag register", rd, 32'h1);
        xfer(clc_pkg::OFF_FLAG, 1'b1, 32'h1);
        drive <= 32'h0;
        settle();
        chk("fall ignored", 32'(irq), 32'h0);
        // Fall interrupt only.
        xfer(clc_pkg::OFF_CTRL, 1'b1, 32'h88);
        drive <= 32'h1 << 27;
        settle();
        chk("rise ignored", 32'(irq), 32'h0);
        drive <= 32'h0;
        settle();
        chk("fall sets flag", 32'(irq), 32'h1);
        xfer(clc_pkg::OFF_FLAG, 1'b1, 32'h1);
        chk("flag cleared again", 32'(irq), 32'h0);
        drive <= (32'h1 << 27) | (32'h1 << 6);
        settle();
        xfer(clc_pkg::OFF_MIRROR, 1'b0, 32'h0);
        chk("mirror", rd, 32'h5);
        xfer(clc_pkg::OFF_SEL, 1'b1, 32'h0805131b);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(clc_pkg::OFF_SEL, 1'b0, 32'h0);
        chk("select kept", rd, 32'h0805131b);
        xfer(clc_pkg::OFF_GATE, 1'b0, 32'h0);
        chk("gate kept", rd, 32'h2);
        xfer(clc_pkg::OFF_CTRL, 1'b0, 32'h0);
        chk("ctrl cleared", rd, 32'h0);
        chk("output off", 32'(out), 32'h0);
        xfer(clc_pkg::OFF_POL, 1'b0, 32'h0);
        chk("polarity kept", rd, 32'h2);
        // The system clock source toggles the output each cycle and keeps setting the flag.
        xfer(clc_pkg::OFF_SEL, 1'b1, {27'h0, clc_pkg::SEL_SYS_CLK});
        xfer(clc_pkg::OFF_CTRL, 1'b1, 32'h90);
        settle();
        prev_out = out;
        @(posedge pclk);
        chk("system clock toggles", 32'(out ^ prev_out), 32'h1);
        xfer(clc_pkg::OFF_FLAG, 1'b1, 32'h1);
        xfer(clc_pkg::OFF_FLAG, 1'b1, 32'h1);
        settle();
        chk("edge beats clear", 32'(irq), 32'h1);
        // Empty gates leave only their polarity bits.
        xfer(clc_pkg::OFF_GATE, 1'b1, 32'h0);
        xfer(clc_pkg::OFF_POL, 1'b1, 32'hf);
        xfer(clc_pkg::OFF_CTRL, 1'b1, 32'h82);
        settle();
        chk("empty gates inverted", 32'(out), 32'h1);
        finish_test();
    end
endmodule // tb_configurable_logic_cell
`default_nettype wire
